// ### rtl/drc_cfg.svh
// constants for the dram refresh and dll mode control block
// assumes inclusion by drc_pkg and design modules
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH

`define DRC_ADDR_REFCTL 12'h000
`define DRC_ADDR_STATUS 12'h004
`define DRC_ADDR_ROWCNT 12'h008
`define DRC_ADDR_MODE 12'h00c
`define DRC_ADDR_LAT 12'h010
`define DRC_ADDR_REFCNT 12'h014
`define DRC_CLK_MHZ 125
`define DRC_TRFC_NS 260
`define DRC_TRFC_CYC ((`DRC_TRFC_NS * `DRC_CLK_MHZ + 999) / 1000)
`define DRC_CL_DLL_OFF 4'h6
`define DRC_CWL_DLL_OFF 4'h6
`define DRC_CL_RESET 4'h6
`define DRC_CWL_RESET 4'h5
`define DRC_AL_RESET 4'h0
`define DRC_BIT_DLL_OFF 0
`define DRC_BIT_SELF_REF 1
`define DRC_BIT_CMD_REF 2
`define DRC_BIT_CMD_DES 3
`define DRC_BIT_BUSY 0
`define DRC_BIT_LAT_ERR 3
`define DRC_LAT_AL_HI 11
`define DRC_LAT_AL_LO 8
`define DRC_LAT_CL_HI 7
`define DRC_LAT_CL_LO 4
`define DRC_LAT_CWL_HI 3
`define DRC_LAT_CWL_LO 0
`define DRC_CMD_ADDR_HI 31
`define DRC_CMD_ADDR_LO 16

`endif

// ### rtl/drc_pkg.sv
// types shared by the refresh and dll mode control block
// assumes drc_cfg.svh on the include path
`include "drc_cfg.svh"

package drc_pkg;

    // command seen on the command pins in one cycle
    typedef struct packed {
        logic deselect;
        logic refresh;
        logic [15:0] addr;
    } drc_cmd_t;

    // latency set in force
    typedef struct packed {
        logic [3:0] al;
        logic [3:0] cl;
        logic [3:0] cwl;
    } drc_lat_t;

    typedef enum logic [1:0] {
        DRC_ST_NORMAL = 2'b00,
        DRC_ST_REFRESH = 2'b01,
        DRC_ST_SELF = 2'b10
    } drc_state_t;

endpackage

// ### rtl/drc_row_counter.sv
// internal refresh row counter
// assumes one clock and an active low async reset
`timescale 1ns/10ps
`default_nettype none

module drc_row_counter
    import drc_pkg::*;
#(
    parameter int ROW_BITS = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    output logic [ROW_BITS-1:0] row
);
    initial begin
        if (ROW_BITS < 1 || ROW_BITS > 16) begin
            $error("drc_row_counter: ROW_BITS out of range");
        end
    end

    // advance one row group per registered refresh, wrap after the last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row <= '0;
        end else if (step) begin
            row <= row + 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### rtl/drc_busy_timer.sv
// down counter that holds the refresh period busy
// assumes one clock and an active low async reset
`timescale 1ns/10ps
`default_nettype none

module drc_busy_timer
    import drc_pkg::*;
#(
    parameter int COUNT = 33
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic busy
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_reg;

    initial begin
        if (COUNT < 1) begin
            $error("drc_busy_timer: COUNT must be at least one");
        end
    end

    // period runs from the registering edge for COUNT cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (start) begin
            cnt_reg <= W'(COUNT);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy = (cnt_reg != '0);
endmodule

`default_nettype wire

// ### rtl/drc_top.sv
// refresh scheduling, self refresh and dll disable mode control of the dram
// assumes an apb master on pclk and a controller that keeps its own timing
//
// Operation
// - refresh ignores address inputs, row internal
// - refresh period lasts trfc from registration
// - self refresh retains data without clock
// - mode register 1 bit 0 disables dll
// - dll off supports only cl6 cwl6
// - dll off strobe reference one cycle earlier
// - deselect blocks new commands only
`timescale 1ns/10ps
`default_nettype none
`include "drc_cfg.svh"

module drc_top
    import drc_pkg::*;
#(
    parameter int ROW_BITS = 13,
    parameter int TRFC_CYC = `DRC_TRFC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic refresh_busy,
    output logic dll_off,
    output logic self_refresh,
    output logic [3:0] strobe_ref_lat
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    initial begin
        if (ROW_BITS < 1 || ROW_BITS > 16) begin
            $error("drc_top: ROW_BITS out of range");
        end
        if (TRFC_CYC < 1) begin
            $error("drc_top: TRFC_CYC must be at least one");
        end
    end

    // ************************************************************
    // apb decode
    // ************************************************************
    wire logic wr_en;
    wire logic rd_en;
    wire logic hit_refctl;
    wire logic hit_status;
    wire logic hit_rowcnt;
    wire logic hit_mode;
    wire logic hit_lat;
    wire logic hit_refcnt;
    wire logic hit_any;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign hit_refctl = addr_is(paddr, `DRC_ADDR_REFCTL);
    assign hit_status = addr_is(paddr, `DRC_ADDR_STATUS);
    assign hit_rowcnt = addr_is(paddr, `DRC_ADDR_ROWCNT);
    assign hit_mode = addr_is(paddr, `DRC_ADDR_MODE);
    assign hit_lat = addr_is(paddr, `DRC_ADDR_LAT);
    assign hit_refcnt = addr_is(paddr, `DRC_ADDR_REFCNT);
    assign hit_any = hit_refctl | hit_status | hit_rowcnt | hit_mode | hit_lat | hit_refcnt;

    // ************************************************************
    // command decode
    // ************************************************************
    drc_cmd_t cmd;
    drc_lat_t lat_reg;
    drc_lat_t lat_next;
    drc_state_t state_reg;
    drc_state_t state_next;
    logic dll_off_reg;
    logic lat_err_reg;
    logic [31:0] refcnt_reg;
    logic [ROW_BITS-1:0] row;
    wire logic busy;
    wire logic take_ref;
    wire logic cmd_ok;
    wire logic want_dll_off;
    wire logic want_self;
    wire logic lat_legal;
    wire logic [3:0] wr_al;
    wire logic [3:0] wr_cl;
    wire logic [3:0] wr_cwl;
    wire logic in_self;
    wire logic lat_err_set;
    wire logic lat_err_clr;
    wire logic mode_wr;
    wire logic lat_wr;
    wire logic [31:0] status_word;
    wire logic [31:0] mode_word;
    wire logic [31:0] lat_word;
    wire logic [31:0] row_word;

    // command pins as written through the command register
    assign cmd.deselect = wr_en && hit_refctl && pwdata[`DRC_BIT_CMD_DES];
    assign cmd.refresh = wr_en && hit_refctl && pwdata[`DRC_BIT_CMD_REF];
    assign cmd.addr = pwdata[`DRC_CMD_ADDR_HI:`DRC_CMD_ADDR_LO]; // never used for refresh

    // deselect stops a new command; running refresh period is untouched
    assign cmd_ok = !cmd.deselect;
    // row address comes from the internal counter only
    assign take_ref = cmd.refresh && cmd_ok && (state_reg == DRC_ST_NORMAL) && !busy;
    assign want_dll_off = pwdata[`DRC_BIT_DLL_OFF];
    assign want_self = pwdata[`DRC_BIT_SELF_REF];

    // ************************************************************
    // register write strobes and fields
    // ************************************************************
    assign mode_wr = wr_en && hit_mode;
    assign lat_wr = wr_en && hit_lat;
    // latency fields of a latency register write
    assign wr_al = pwdata[`DRC_LAT_AL_HI:`DRC_LAT_AL_LO];
    assign wr_cl = pwdata[`DRC_LAT_CL_HI:`DRC_LAT_CL_LO];
    assign wr_cwl = pwdata[`DRC_LAT_CWL_HI:`DRC_LAT_CWL_LO];
    // a refused latency write raises the error, writing one to it clears it
    assign lat_err_set = lat_wr && !lat_legal;
    assign lat_err_clr = wr_en && hit_status && pwdata[`DRC_BIT_LAT_ERR];

    drc_row_counter #(
        .ROW_BITS(ROW_BITS)
    ) u_row (
        .pclk(pclk),
        .presetn(presetn),
        .step(take_ref),
        .row(row)
    );

    drc_busy_timer #(
        .COUNT(TRFC_CYC)
    ) u_busy (
        .pclk(pclk),
        .presetn(presetn),
        .start(take_ref),
        .busy(busy)
    );

    // ************************************************************
    // self refresh and refresh state
    // ************************************************************
    // self refresh holds the array with no need for the clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DRC_ST_NORMAL: begin
                if (take_ref) begin
                    state_next = DRC_ST_REFRESH;
                end else if (mode_wr && want_self && cmd_ok && !busy) begin
                    state_next = DRC_ST_SELF;
                end
            end
            DRC_ST_REFRESH: begin
                if (!busy) begin
                    state_next = DRC_ST_NORMAL;
                end
            end
            DRC_ST_SELF: begin
                if (mode_wr && !want_self) begin
                    state_next = DRC_ST_NORMAL;
                end
            end
            default: begin
                state_next = DRC_ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DRC_ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // dll mode and latency
    // ************************************************************
    // latency write with dll off takes only the supported pair; turning dll off forces it
    assign lat_legal = !dll_off_reg ||
        (wr_cl == `DRC_CL_DLL_OFF && wr_cwl == `DRC_CWL_DLL_OFF);
    always_comb begin
        lat_next = lat_reg;
        if (lat_wr && lat_legal) begin
            lat_next.al = wr_al;
            lat_next.cl = wr_cl;
            lat_next.cwl = wr_cwl;
        end else if (mode_wr && want_dll_off && !dll_off_reg) begin
            lat_next.cl = `DRC_CL_DLL_OFF;
            lat_next.cwl = `DRC_CWL_DLL_OFF;
        end
    end

    // mode bit 0 set turns the dll off, cleared turns it on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_off_reg <= 1'b0;
            lat_reg <= '{al: `DRC_AL_RESET, cl: `DRC_CL_RESET, cwl: `DRC_CWL_RESET};
            lat_err_reg <= 1'b0;
        end else begin
            if (mode_wr) begin
                dll_off_reg <= want_dll_off;
            end
            lat_reg <= lat_next;
            if (lat_err_set) begin
                lat_err_reg <= 1'b1;
            end else if (lat_err_clr) begin
                lat_err_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // refresh count
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refcnt_reg <= 32'h0;
        end else if (take_ref) begin
            refcnt_reg <= refcnt_reg + 32'h1;
        end
    end

    // ************************************************************
    // outputs and apb read
    // ************************************************************
    // strobe window reference: al+cl, one earlier with dll off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_ref_lat <= 4'h0;
            refresh_busy <= 1'b0;
            dll_off <= 1'b0;
            self_refresh <= 1'b0;
        end else begin
            strobe_ref_lat <= lat_reg.al + lat_reg.cl - {3'h0, dll_off_reg};
            refresh_busy <= busy | take_ref;
            dll_off <= dll_off_reg;
            self_refresh <= (state_next == DRC_ST_SELF);
        end
    end

    // self refresh state as software sees it
    assign in_self = (state_reg == DRC_ST_SELF);
    // read words, unused bits zero
    assign status_word = {28'h0, lat_err_reg, in_self, dll_off_reg, busy};
    assign mode_word = {30'h0, in_self, dll_off_reg};
    assign lat_word = {20'h0, lat_reg.al, lat_reg.cl, lat_reg.cwl};
    assign row_word = {{(32 - ROW_BITS){1'b0}}, row};

    // read data captured in setup, write completes in access, no waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (rd_en) begin
                prdata <= 32'h0;
                if (hit_status) begin
                    prdata <= status_word;
                end else if (hit_rowcnt) begin
                    prdata <= row_word;
                end else if (hit_mode) begin
                    prdata <= mode_word;
                end else if (hit_lat) begin
                    prdata <= lat_word;
                end else if (hit_refcnt) begin
                    prdata <= refcnt_reg;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### verification/drc_top_props.sv
// port checker for the refresh and dll mode control block
// assumes bind onto drc_top, one clock, async low reset
`timescale 1ns/10ps
`default_nettype none

module drc_top_props #(
    parameter int TRFC_CYC = 33
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic refresh_busy,
    input wire logic dll_off,
    input wire logic self_refresh,
    input wire logic [3:0] strobe_ref_lat
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed transfers by target
    wire acc = psel && penable && pready;
    wire cmd_wr = acc && pwrite && paddr == 12'h000;
    wire mode_wr = acc && pwrite && paddr == 12'h00c;
    wire lat_wr = acc && pwrite && paddr == 12'h010;
    wire ref_req = cmd_wr && pwdata[2] && !refresh_busy;
    logic [7:0] busy_n;
    logic [3:0] lat_sum;
    // busy stretch length and last written al+cl
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_n <= 8'h00;
            lat_sum <= 4'h0;
        end else begin
            busy_n <= refresh_busy ? busy_n + 8'h01 : 8'h00;
            lat_sum <= lat_wr ? pwdata[11:8] + pwdata[7:4] : lat_sum;
        end
    end
    a_ref_start: assert property (
        ref_req && !pwdata[3] && !self_refresh |-> ##[1:2] refresh_busy)
        else $error("refresh did not start");
    a_busy_len: assert property (busy_n <= TRFC_CYC + 1)
        else $error("refresh period too long");
    a_busy_exact: assert property ($fell(refresh_busy) |-> busy_n == TRFC_CYC + 1)
        else $error("refresh period wrong length");
    a_ref_blocked: assert property (
        ref_req && (pwdata[3] || self_refresh) |=> !refresh_busy [*3])
        else $error("refresh ran while blocked");
    a_dll_follow: assert property (
        mode_wr |-> ##2 dll_off == $past(pwdata[0], 2))
        else $error("dll_off does not follow mode");
    a_self_follow: assert property (
        mode_wr && !refresh_busy |-> ##2 self_refresh == $past(pwdata[1], 2))
        else $error("self_refresh does not follow mode");
    a_lat_locked: assert property (
        lat_wr && dll_off && pwdata[7:0] != 8'h66 |=> $stable(strobe_ref_lat) [*2])
        else $error("latency changed with dll off");
    a_strobe_sum: assert property (
        lat_wr && !dll_off |=> ##[0:1] strobe_ref_lat == lat_sum)
        else $error("strobe reference not al plus cl");
    a_unmapped_err: assert property (acc && paddr > 12'h014 |-> pslverr)
        else $error("no error on unmapped address");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
endmodule

bind drc_top drc_top_props #(.TRFC_CYC(TRFC_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refresh_busy(refresh_busy),
    .dll_off(dll_off), .self_refresh(self_refresh), .strobe_ref_lat(strobe_ref_lat)
);
`default_nettype wire

// ### verification/drc_ctl_model.sv
// controller model driving the apb side of the block
// assumes calls begin at a rising edge of pclk
`timescale 1ns/10ps
`default_nettype none

module drc_ctl_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // one transfer per command, each refresh its own write
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the refresh and dll mode control block
// assumes drc_ctl_model as apb master and small count parameters
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, refresh_busy, dll_off, self_refresh, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] strobe_ref_lat;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    typedef struct {logic [11:0] a; logic w; logic [31:0] d, q; logic e;} drc_row_t;
    // address, write, data, read expected, error expected
    drc_row_t rows[10] = '{
        '{12'h000, 1'b0, 32'h0, 32'h0, 1'b0}, '{12'h004, 1'b0, 32'h0, 32'h0, 1'b0},
        '{12'h008, 1'b0, 32'h0, 32'h0, 1'b0}, '{12'h00c, 1'b0, 32'h0, 32'h0, 1'b0},
        '{12'h010, 1'b0, 32'h0, 32'h65, 1'b0}, '{12'h014, 1'b0, 32'h0, 32'h0, 1'b0},
        '{12'h018, 1'b0, 32'h0, 32'h0, 1'b1}, '{12'h020, 1'b1, 32'h1, 32'h0, 1'b1},
        '{12'h010, 1'b1, 32'h285, 32'h0, 1'b0}, '{12'h010, 1'b0, 32'h0, 32'h285, 1'b0}};

    always #4 pclk = ~pclk;

    drc_top #(.ROW_BITS(2), .TRFC_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .refresh_busy(refresh_busy),
        .dll_off(dll_off), .self_refresh(self_refresh), .strobe_ref_lat(strobe_ref_lat));
    drc_ctl_model ctl (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ctl.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        ctl.xfer(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask
    // wait out a refresh period
    task automatic idle();
        @(posedge pclk);
        while (refresh_busy !== 1'b0) begin
            @(posedge pclk);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            ctl.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
            if (!rows[i].w) check(q, rows[i].q);
            check(32'(e), 32'(rows[i].e));
        end
        check(32'(strobe_ref_lat), 32'ha);
        wr(12'h00c, 32'h1);
        rd(12'h010, 32'h266);
        check(32'(dll_off), 32'h1);
        check(32'(strobe_ref_lat), 32'h7);
        wr(12'h010, 32'h75);
        rd(12'h010, 32'h266);
        rd(12'h004, 32'ha);
        wr(12'h004, 32'h8);
        wr(12'h010, 32'h66);
        rd(12'h004, 32'h2);
        check(32'(strobe_ref_lat), 32'h5);
        wr(12'h00c, 32'h0);
        rd(12'h010, 32'h66);
        check(32'(strobe_ref_lat), 32'h6);
        wr(12'h000, 32'hffff0004);
        rd(12'h004, 32'h1);
        wr(12'h000, 32'h4);
        idle();
        rd(12'h014, 32'h1);
        rd(12'h008, 32'h1);
        wr(12'h000, 32'hc);
        rd(12'h014, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(12'h000, 32'h4);
            idle();
        end
        rd(12'h008, 32'h0);
        wr(12'h00c, 32'h1);
        wr(12'h00c, 32'h3);
        wr(12'h000, 32'h4);
        rd(12'h004, 32'h6);
        check(32'(self_refresh), 32'h1);
        rd(12'h014, 32'h4);
        wr(12'h00c, 32'h1);
        rd(12'h004, 32'h2);
        check(32'(self_refresh), 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        check(32'({dll_off, self_refresh, refresh_busy, strobe_ref_lat}), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h010, 32'h65);
        rd(12'h004, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
